// ==== bench/pch_checker_properties.sv ====
`timescale 1ns/100ps
module pch_checker (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        cfg_req,
  input wire logic        cfg_write,
  input wire logic [7:2]  cfg_index,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic        cfg_ack_q,
  input wire logic        mem_addr_valid,
  input wire logic        reg_claim_q,
  input wire logic        array_claim_q,
  input wire logic        master_enable_q,
  input wire logic        ee_clk_q,
  input wire logic        ee_sel_q
);
  logic rd;
  assign rd = cfg_req && !cfg_write;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  chk_ack_follows: assert property (cfg_req |=> cfg_ack_q) else $error("no ack");
  chk_ack_alone: assert property (!cfg_req |=> !cfg_ack_q) else $error("stray ack");
  chk_master_write: assert property (cfg_req && cfg_write && cfg_index == 6'h01 && cfg_be[0]
    |-> ##2 master_enable_q == $past(cfg_wdata[2], 2)) else $error("master enable wrong");
  chk_master_reset: assert property ($rose(nrst) |-> !master_enable_q) else $error("master set");
  chk_cmd_fixed: assert property (rd && cfg_index == 6'h01
    |=> cfg_rdata_q[31:16] == 16'h0200 && !cfg_rdata_q[5] && !cfg_rdata_q[3]) else $error("command word");
  chk_class_fixed: assert property (rd && cfg_index == 6'h02
    |=> cfg_rdata_q[31:8] == 24'h040100) else $error("class code");
  chk_header_zero: assert property (rd && cfg_index == 6'h03
    |=> cfg_rdata_q[31:16] == 16'h0 && cfg_rdata_q[10:8] == 3'h0) else $error("header word");
  chk_base_low: assert property (rd && cfg_index == 6'h04 |=> cfg_rdata_q[11:0] == 12'h0)
    else $error("base zero low");
  chk_array_low: assert property (rd && cfg_index == 6'h05 |=> cfg_rdata_q[15:0] == 16'h0)
    else $error("base one low");
  chk_unused_zero: assert property (rd && cfg_index inside {[6'h06:6'h0a]}
    |=> cfg_rdata_q == 32'h0) else $error("unused nonzero");
  chk_claim_cause: assert property (reg_claim_q || array_claim_q |-> $past(mem_addr_valid, 2))
    else $error("claim without cycle");
  chk_sel_clock: assert property (!ee_sel_q |-> !ee_clk_q) else $error("serial clock idle");
endmodule : pch_checker

bind pch_top pch_checker chk (.clock, .nrst, .cfg_req, .cfg_write, .cfg_index, .cfg_be, .cfg_wdata,
  .cfg_rdata_q, .cfg_ack_q, .mem_addr_valid, .reg_claim_q, .array_claim_q, .master_enable_q,
  .ee_clk_q, .ee_sel_q);

// ==== bench/pch_serial_mem.sv ====
`timescale 1ns/100ps
module pch_serial_mem #(parameter logic [31:0] WORD = 32'h5a5ac3c3) (
  input  wire logic ee_clk_q,
  input  wire logic ee_sel_q,
  output logic      ee_data_in
);
  logic [31:0] sh_q = WORD;
  // Reload per fetch, shift after each sampling edge, MSB first
  always @(posedge ee_sel_q) sh_q = WORD;
  always @(posedge ee_clk_q) sh_q = {sh_q[30:0], ~sh_q[31]};
  // Deselected line shows the inverse of the last bit
  assign ee_data_in = ee_sel_q ? sh_q[31] : ~sh_q[31];
endmodule : pch_serial_mem

// ==== bench/test_pci_config_header_space.sv ====
`timescale 1ns/100ps
module test_pci_config_header_space;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        cfg_req = 1'b0;
  logic        cfg_write = 1'b0;
  logic [7:2]  cfg_index = 6'h00;
  logic [3:0]  cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic        mem_addr_valid = 1'b0;
  logic [31:0] mem_addr = 32'h0;
  logic        ee_present = 1'b0;
  logic [31:0] cfg_rdata_q;
  logic        cfg_ack_q, reg_claim_q, array_claim_q, master_enable_q, ee_data_in, ee_clk_q, ee_sel_q;
  int          fail_count = 0;
  int          checks = 0;

  always #10 clock = ~clock;

  pch_top dut (.clock, .nrst, .cfg_req, .cfg_write, .cfg_index, .cfg_be, .cfg_wdata, .cfg_rdata_q,
    .cfg_ack_q, .mem_addr_valid, .mem_addr, .reg_claim_q, .array_claim_q, .master_enable_q,
    .ee_present, .ee_data_in, .ee_clk_q, .ee_sel_q);
  pch_serial_mem ee_mem (.ee_clk_q, .ee_sel_q, .ee_data_in);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:2] idx, input logic [3:0] be, input logic [31:0] d);
    @(negedge clock);
    cfg_req = 1'b1;
    cfg_write = w;
    cfg_index = idx;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge clock);
    cfg_req = 1'b0;
    chk("config ack", 32'h1, {31'h0, cfg_ack_q});
  endtask : acc

  task automatic wr(input logic [7:2] idx, input logic [31:0] d);
    acc(1'b1, idx, 4'hf, d);
  endtask : wr

  task automatic rd(input logic [7:2] idx, input logic [31:0] exp);
    acc(1'b0, idx, 4'hf, 32'h0);
    chk($sformatf("read %h", idx), exp, cfg_rdata_q);
  endtask : rd

  task automatic probe(input logic [31:0] a, input logic r, input logic y);
    @(negedge clock);
    mem_addr_valid = 1'b1;
    mem_addr = a;
    @(negedge clock);
    mem_addr_valid = 1'b0;
    chk("early claim", 32'h0, {30'h0, reg_claim_q, array_claim_q});
    @(negedge clock);
    chk("register claim", {31'h0, r}, {31'h0, reg_claim_q});
    chk("array claim", {31'h0, y}, {31'h0, array_claim_q});
  endtask : probe

  task automatic do_reset(input logic present);
    nrst = 1'b0;
    ee_present = present;
    repeat (4) @(negedge clock);
    nrst = 1'b1;
  endtask : do_reset

  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  initial begin
    #1000000;
    fail_count++;
    end_sim();
  end

  initial begin
    do_reset(1'b0);
    rd(6'h0b, 32'h0);
    wr(6'h3f, 32'h12345678);
    rd(6'h0b, 32'h0);
    wr(6'h0b, 32'hffffffff);
    rd(6'h0b, 32'h0);
    wr(6'h38, pch_pkg::GUARD_KEY);
    acc(1'b1, 6'h3f, 4'h3, 32'haaaa5555);
    rd(6'h0b, 32'h00005555);
    wr(6'h3f, 32'h9abcdef0);
    rd(6'h0b, 32'h9abcdef0);
    wr(6'h39, 32'h11223344);
    wr(6'h38, 32'h0);
    wr(6'h39, 32'h0);
    rd(6'h39, 32'h11223344);
    wr(6'h3f, 32'h0);
    rd(6'h0b, 32'h9abcdef0);
    wr(6'h00, 32'h0);
    rd(6'h00, {pch_pkg::DEVICE_CODE, pch_pkg::VENDOR_CODE});
    wr(6'h01, 32'hffffffff);
    @(negedge clock);
    chk("master enable", 32'h1, {31'h0, master_enable_q});
    rd(6'h01, 32'h02000046);
    rd(6'h02, {24'h040100, pch_pkg::REVISION_CODE});
    wr(6'h03, 32'hffffffff);
    rd(6'h03, 32'h0000f800);
    wr(6'h04, 32'hffffffff);
    rd(6'h04, 32'hfffff000);
    wr(6'h05, 32'hffffffff);
    rd(6'h05, 32'hffff0000);
    for (int i = 6; i <= 10; i++) begin
      wr(6'(i), 32'hffffffff);
      rd(6'(i), 32'h0);
    end
    wr(6'h04, 32'h12345678);
    wr(6'h05, 32'habcd1234);
    probe(32'h12345ffc, 1'b1, 1'b0);
    probe(32'h12346000, 1'b0, 1'b0);
    probe(32'habcdfffc, 1'b0, 1'b1);
    probe(32'habce0000, 1'b0, 1'b0);
    acc(1'b1, 6'h01, 4'h1, 32'h0);
    @(negedge clock);
    chk("master enable", 32'h0, {31'h0, master_enable_q});
    probe(32'h12345000, 1'b0, 1'b0);
    do_reset(1'b1);
    rd(6'h01, 32'h02000000);
    chk("serial select", 32'h1, {31'h0, ee_sel_q});
    for (int n = 0; n < 20000 && ee_sel_q === 1'b1; n++)
      @(negedge clock);
    chk("serial select", 32'h0, {31'h0, ee_sel_q});
    rd(6'h0b, 32'h5a5ac3c3);
    end_sim();
  end
endmodule : test_pci_config_header_space

// ==== src/pch_pkg.sv ====
package pch_pkg;
  // Configuration offsets, byte addresses
  localparam logic [7:0]  OFF_IDENT      = 8'h00;
  localparam logic [7:0]  OFF_CMD_STAT   = 8'h04;
  localparam logic [7:0]  OFF_CLASS_REV  = 8'h08;
  localparam logic [7:0]  OFF_HDR_LAT    = 8'h0c;
  localparam logic [7:0]  OFF_BASE0      = 8'h10;
  localparam logic [7:0]  OFF_BASE1      = 8'h14;
  localparam logic [7:0]  OFF_BASE2      = 8'h18;
  localparam logic [7:0]  OFF_BASE3      = 8'h1c;
  localparam logic [7:0]  OFF_BASE4      = 8'h20;
  localparam logic [7:0]  OFF_BASE5      = 8'h24;
  localparam logic [7:0]  OFF_CIS_PTR    = 8'h28;
  localparam logic [7:0]  OFF_SUBSYS     = 8'h2c;
  localparam logic [7:0]  OFF_GUARD      = 8'he0;
  localparam logic [7:0]  OFF_VEND_FIRST = 8'he4;
  localparam logic [7:0]  OFF_SUB_LOAD   = 8'hfc;
  localparam int          VEND_WORDS     = 6;

  // Identity codes, values arbitrary
  localparam logic [15:0] VENDOR_CODE    = 16'h0abc;
  localparam logic [15:0] DEVICE_CODE    = 16'h0123;
  localparam logic [7:0]  REVISION_CODE  = 8'h0a;

  localparam logic [23:0] CLASS_CODE     = 24'h040100;
  localparam logic [7:0]  HEADER_TYPE    = 8'h00;
  localparam logic [7:0]  SELF_TEST      = 8'h00;
  localparam logic [15:0] STATUS_VALUE   = 16'h0200;
  localparam logic [31:0] GUARD_KEY      = 32'h00004281;

  // Writable bit masks
  localparam logic [31:0] CMD_WR_MASK    = 32'h00000046;
  localparam int          CMD_MEM_EN_BIT = 1;
  localparam int          CMD_MASTER_BIT = 2;
  localparam logic [31:0] LAT_WR_MASK    = 32'h0000f800;
  localparam logic [31:0] BASE0_WR_MASK  = 32'hfffff000;
  localparam logic [31:0] BASE1_WR_MASK  = 32'hffff0000;
  localparam logic [31:0] ALL_MASK       = 32'hffffffff;
  localparam logic [31:0] ZERO_WORD      = 32'h00000000;

  // Serial memory timing
  localparam int          CLOCK_MHZ      = 50;
  localparam int          EE_HALF_NS     = 5000;
  localparam int          EE_HALF_CYC    = (EE_HALF_NS * CLOCK_MHZ + 999) / 1000;
  localparam int          EE_BITS        = 32;

  typedef enum logic [1:0] {RD_STRAP, RD_SHIFT, RD_FINISH, RD_DONE} pch_rd_state_t;
endpackage : pch_pkg

// ==== src/pch_sid_if.sv ====
`timescale 1ns/100ps
interface pch_sid_if;
  logic        done;
  logic [31:0] data;

  modport reader (output done, output data);
  modport header (input done, input data);
endinterface : pch_sid_if

// ==== src/pch_sid_reader.sv ====
`timescale 1ns/100ps
module pch_sid_reader (
  input  wire logic   clock,
  input  wire logic   nrst,
  input  wire logic   ee_present,
  input  wire logic   ee_data_in,
  output logic        ee_clk_q,
  output logic        ee_sel_q,
  pch_sid_if.reader   sid
);
  pch_pkg::pch_rd_state_t state_q, state_d;
  logic [15:0] div_q, div_d;
  logic [5:0]  bit_q, bit_d;
  logic [31:0] shift_q, shift_d;
  logic        clk_d, sel_d;
  logic        done_q, done_d;

  always_comb begin
    state_d = state_q;
    div_d   = div_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    clk_d   = ee_clk_q;
    sel_d   = ee_sel_q;
    done_d  = 1'b0;
    case (state_q)
      pch_pkg::RD_STRAP: begin
        // Fetch only when a serial memory is fitted
        if (ee_present) begin
          state_d = pch_pkg::RD_SHIFT;
          sel_d   = 1'b1;
        end else begin
          state_d = pch_pkg::RD_DONE;
        end
      end
      pch_pkg::RD_SHIFT: begin
        if (div_q == 16'(pch_pkg::EE_HALF_CYC - 1)) begin
          div_d = 16'h0000;
          clk_d = ~ee_clk_q;
          if (!ee_clk_q) begin
            shift_d = {shift_q[30:0], ee_data_in};
            bit_d   = bit_q + 6'h01;
            if (bit_q == 6'(pch_pkg::EE_BITS - 1)) begin
              state_d = pch_pkg::RD_FINISH;
            end
          end
        end else begin
          div_d = div_q + 16'h0001;
        end
      end
      pch_pkg::RD_FINISH: begin
        if (div_q == 16'(pch_pkg::EE_HALF_CYC - 1)) begin
          clk_d   = 1'b0;
          sel_d   = 1'b0;
          done_d  = 1'b1;
          state_d = pch_pkg::RD_DONE;
        end else begin
          div_d = div_q + 16'h0001;
        end
      end
      pch_pkg::RD_DONE: begin
        state_d = pch_pkg::RD_DONE;
      end
      default: begin
        state_d = pch_pkg::RD_DONE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q  <= pch_pkg::RD_STRAP;
      div_q    <= 16'h0000;
      bit_q    <= 6'h00;
      shift_q  <= 32'h00000000;
      ee_clk_q <= 1'b0;
      ee_sel_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      div_q    <= div_d;
      bit_q    <= bit_d;
      shift_q  <= shift_d;
      ee_clk_q <= clk_d;
      ee_sel_q <= sel_d;
      done_q   <= done_d;
    end
  end

  assign sid.done = done_q;
  assign sid.data = shift_q;
endmodule : pch_sid_reader

// ==== src/pch_top.sv ====
`timescale 1ns/100ps
module pch_top (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        cfg_req,
  input  wire logic        cfg_write,
  input  wire logic [7:2]  cfg_index,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata_q,
  output logic             cfg_ack_q,
  input  wire logic        mem_addr_valid,
  input  wire logic [31:0] mem_addr,
  output logic             reg_claim_q,
  output logic             array_claim_q,
  output logic             master_enable_q,
  input  wire logic        ee_present,
  input  wire logic        ee_data_in,
  output logic             ee_clk_q,
  output logic             ee_sel_q
);
  pch_sid_if sid ();

  pch_sid_reader u_reader (
    .clock      (clock),
    .nrst       (nrst),
    .ee_present (ee_present),
    .ee_data_in (ee_data_in),
    .ee_clk_q   (ee_clk_q),
    .ee_sel_q   (ee_sel_q),
    .sid        (sid)
  );

  function automatic logic [5:0] idx(input logic [7:0] off);
    idx = off[7:2];
  endfunction : idx

  // Byte-enable merge limited to the writable bits
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be,
                                        input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old_v & ~lanes) | (new_v & lanes);
  endfunction : merge

  logic [31:0] cmd_q, cmd_d;
  logic [31:0] lat_q, lat_d;
  logic [31:0] base0_q, base0_d;
  logic [31:0] base1_q, base1_d;
  logic [31:0] guard_q, guard_d;
  logic [31:0] sub_q, sub_d;
  logic [31:0] vend_q [pch_pkg::VEND_WORDS];
  logic [31:0] vend_d [pch_pkg::VEND_WORDS];
  logic [31:0] rdata_d;
  logic        ack_d;
  logic        unlocked;
  logic        wr;
  logic [5:0]  vend_rel;
  logic        vend_hit;

  assign unlocked = (guard_q == pch_pkg::GUARD_KEY);
  assign wr       = cfg_req && cfg_write;
  assign vend_rel = cfg_index - idx(pch_pkg::OFF_VEND_FIRST);
  assign vend_hit = (cfg_index >= idx(pch_pkg::OFF_VEND_FIRST)) && (cfg_index < idx(pch_pkg::OFF_SUB_LOAD));

  // Write side of the header
  always_comb begin
    cmd_d   = cmd_q;
    lat_d   = lat_q;
    base0_d = base0_q;
    base1_d = base1_q;
    guard_d = guard_q;
    sub_d   = sub_q;
    for (int i = 0; i < pch_pkg::VEND_WORDS; i++) begin
      vend_d[i] = vend_q[i];
    end
    if (wr) begin
      case (cfg_index)
        idx(pch_pkg::OFF_CMD_STAT): begin
          cmd_d = merge(cmd_q, cfg_wdata, cfg_be, pch_pkg::CMD_WR_MASK);
        end
        idx(pch_pkg::OFF_HDR_LAT): begin
          lat_d = merge(lat_q, cfg_wdata, cfg_be, pch_pkg::LAT_WR_MASK);
        end
        idx(pch_pkg::OFF_BASE0): begin
          base0_d = merge(base0_q, cfg_wdata, cfg_be, pch_pkg::BASE0_WR_MASK);
        end
        idx(pch_pkg::OFF_BASE1): begin
          base1_d = merge(base1_q, cfg_wdata, cfg_be, pch_pkg::BASE1_WR_MASK);
        end
        idx(pch_pkg::OFF_GUARD): begin
          guard_d = merge(guard_q, cfg_wdata, cfg_be, pch_pkg::ALL_MASK);
        end
        idx(pch_pkg::OFF_SUB_LOAD): begin
          if (unlocked) begin
            sub_d = merge(sub_q, cfg_wdata, cfg_be, pch_pkg::ALL_MASK);
          end
        end
        default: begin
          if (vend_hit && unlocked) begin
            vend_d[vend_rel[2:0]] = merge(vend_q[vend_rel[2:0]], cfg_wdata, cfg_be, pch_pkg::ALL_MASK);
          end
          // Other offsets keep their value, no error raised
        end
      endcase
    end
    // Serial memory result takes precedence over a host load in the same cycle
    if (sid.done) begin
      sub_d = sid.data;
    end
  end

  // Read side of the header
  always_comb begin
    rdata_d = pch_pkg::ZERO_WORD;
    ack_d   = cfg_req;
    case (cfg_index)
      idx(pch_pkg::OFF_IDENT): begin
        rdata_d = {pch_pkg::DEVICE_CODE, pch_pkg::VENDOR_CODE};
      end
      idx(pch_pkg::OFF_CMD_STAT): begin
        rdata_d = {pch_pkg::STATUS_VALUE, cmd_q[15:0]};
      end
      idx(pch_pkg::OFF_CLASS_REV): begin
        rdata_d = {pch_pkg::CLASS_CODE, pch_pkg::REVISION_CODE};
      end
      idx(pch_pkg::OFF_HDR_LAT): begin
        rdata_d = {pch_pkg::SELF_TEST, pch_pkg::HEADER_TYPE, lat_q[15:0]};
      end
      idx(pch_pkg::OFF_BASE0): begin
        rdata_d = base0_q;
      end
      idx(pch_pkg::OFF_BASE1): begin
        rdata_d = base1_q;
      end
      idx(pch_pkg::OFF_BASE2), idx(pch_pkg::OFF_BASE3), idx(pch_pkg::OFF_BASE4),
      idx(pch_pkg::OFF_BASE5), idx(pch_pkg::OFF_CIS_PTR): begin
        rdata_d = pch_pkg::ZERO_WORD;
      end
      idx(pch_pkg::OFF_SUBSYS): begin
        rdata_d = sub_q;
      end
      idx(pch_pkg::OFF_GUARD): begin
        rdata_d = guard_q;
      end
      idx(pch_pkg::OFF_SUB_LOAD): begin
        rdata_d = sub_q;
      end
      default: begin
        if (vend_hit) begin
          rdata_d = vend_q[vend_rel[2:0]];
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_q       <= pch_pkg::ZERO_WORD;
      lat_q       <= pch_pkg::ZERO_WORD;
      base0_q     <= pch_pkg::ZERO_WORD;
      base1_q     <= pch_pkg::ZERO_WORD;
      guard_q     <= pch_pkg::ZERO_WORD;
      sub_q       <= pch_pkg::ZERO_WORD;
      cfg_rdata_q <= pch_pkg::ZERO_WORD;
      cfg_ack_q   <= 1'b0;
      for (int i = 0; i < pch_pkg::VEND_WORDS; i++) begin
        vend_q[i] <= pch_pkg::ZERO_WORD;
      end
    end else begin
      cmd_q       <= cmd_d;
      lat_q       <= lat_d;
      base0_q     <= base0_d;
      base1_q     <= base1_d;
      guard_q     <= guard_d;
      sub_q       <= sub_d;
      cfg_rdata_q <= rdata_d;
      cfg_ack_q   <= ack_d;
      for (int i = 0; i < pch_pkg::VEND_WORDS; i++) begin
        vend_q[i] <= vend_d[i];
      end
    end
  end

  // Address decode, two stages for medium select timing
  logic reg_hit_q, reg_hit_d;
  logic arr_hit_q, arr_hit_d;
  logic reg_claim_d, arr_claim_d, master_d;

  always_comb begin
    reg_hit_d   = mem_addr_valid && cmd_q[pch_pkg::CMD_MEM_EN_BIT]
                  && (mem_addr[31:12] == base0_q[31:12]);
    arr_hit_d   = mem_addr_valid && cmd_q[pch_pkg::CMD_MEM_EN_BIT]
                  && (mem_addr[31:16] == base1_q[31:16]);
    reg_claim_d = reg_hit_q;
    arr_claim_d = arr_hit_q;
    master_d    = cmd_q[pch_pkg::CMD_MASTER_BIT];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_hit_q       <= 1'b0;
      arr_hit_q       <= 1'b0;
      reg_claim_q     <= 1'b0;
      array_claim_q   <= 1'b0;
      master_enable_q <= 1'b0;
    end else begin
      reg_hit_q       <= reg_hit_d;
      arr_hit_q       <= arr_hit_d;
      reg_claim_q     <= reg_claim_d;
      array_claim_q   <= arr_claim_d;
      master_enable_q <= master_d;
    end
  end
endmodule : pch_top
